// [flash_host_pkg.sv]
package flash_host_pkg;

  // clock
  localparam int CLK_PERIOD_NS = 8;

  // bus cycle timing, least times in ns
  localparam int T_SETUP_NS = 10;
  localparam int T_WPULSE_NS = 40;
  localparam int T_RPULSE_NS = 70;
  localparam int T_HOLD_NS = 10;
  localparam int T_BUSY_NS = 90;

  localparam logic [7:0] SETUP_CYC  = 8'((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] WPULSE_CYC = 8'((T_WPULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] RPULSE_CYC = 8'((T_RPULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] HOLD_CYC   = 8'((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] BUSY_CYC   = 8'((T_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // register offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_ADDR   = 8'h04;
  localparam logic [7:0] OFS_WDATA  = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_RDATA0 = 8'h10;
  localparam logic [7:0] OFS_RDATA1 = 8'h14;
  localparam logic [7:0] OFS_RDATA2 = 8'h18;

  // ctrl fields
  localparam int CTRL_CMD_LSB = 0;
  localparam int CTRL_MODE_LSB = 4;

  // status bits
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_BYPASS = 3;
  localparam int ST_RB_PIN = 4;
  localparam int ST_REFUSED = 5;
  localparam int ST_SUSP = 6;

  // commands
  localparam logic [3:0] CMD_READ       = 4'h0;
  localparam logic [3:0] CMD_RESET      = 4'h1;
  localparam logic [3:0] CMD_PROG       = 4'h2;
  localparam logic [3:0] CMD_BYP_ENTER  = 4'h3;
  localparam logic [3:0] CMD_BYP_PROG   = 4'h4;
  localparam logic [3:0] CMD_BYP_RESET  = 4'h5;
  localparam logic [3:0] CMD_CHIP_ERASE = 4'h6;
  localparam logic [3:0] CMD_SECT_ERASE = 4'h7;
  localparam logic [3:0] CMD_SUSPEND    = 4'h8;
  localparam logic [3:0] CMD_RESUME     = 4'h9;
  localparam logic [3:0] CMD_AUTOSEL    = 4'ha;
  localparam logic [3:0] CMD_QUERY      = 4'hb;

  // poll modes
  localparam logic [1:0] MODE_DQ7 = 2'h0;
  localparam logic [1:0] MODE_TOGGLE = 2'h1;
  localparam logic [1:0] MODE_PIN = 2'h2;

  // step kinds
  localparam logic [1:0] K_WR = 2'h0;
  localparam logic [1:0] K_RD = 2'h1;
  localparam logic [1:0] K_POLL = 2'h2;
  localparam logic [1:0] K_END = 2'h3;

  // word-mode unlock offsets and id offsets
  localparam logic [10:0] U_555 = 11'h555;
  localparam logic [10:0] U_2AA = 11'h2aa;
  localparam logic [10:0] ID_1 = 11'h001;
  localparam logic [10:0] ID_2 = 11'h00e;
  localparam logic [10:0] ID_3 = 11'h00f;

  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

endpackage

// [flash_cycle.sv]
`timescale 1ns/100ps
module flash_cycle
  import flash_host_pkg::*;
#(
  parameter int AW = 22,
  parameter int DW = 16
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          sys_rst,
  // request
  input  wire logic          start,
  input  wire logic          is_read,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic               done,
  output logic [DW-1:0]      rdata,
  // flash pins
  output logic [AW-1:0]      flash_addr,
  output logic [DW-1:0]      flash_dq_o,
  output logic               flash_dq_oe,
  input  wire logic [DW-1:0] flash_dq_i,
  output logic               flash_ce_n,
  output logic               flash_we_n,
  output logic               flash_oe_n
);

  typedef enum logic [1:0] {PH_IDLE, PH_SETUP, PH_PULSE, PH_HOLD} phase_e;
  phase_e     ph_q;
  logic [7:0] cnt_q;
  logic       rd_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ph_q        <= PH_IDLE;
      cnt_q       <= 8'h00;
      rd_q        <= 1'b0;
      done        <= 1'b0;
      rdata       <= '0;
      flash_addr  <= '0;
      flash_dq_o  <= '0;
      flash_dq_oe <= 1'b0;
      flash_ce_n  <= 1'b1;
      flash_we_n  <= 1'b1;
      flash_oe_n  <= 1'b1;
    end else begin
      done <= 1'b0;
      case (ph_q)
        PH_IDLE: begin
          if (start) begin
            // address and data settle before either strobe falls
            flash_addr  <= addr;
            flash_dq_o  <= wdata;
            flash_dq_oe <= !is_read;
            rd_q        <= is_read;
            cnt_q       <= SETUP_CYC;
            ph_q        <= PH_SETUP;
          end
        end
        PH_SETUP: begin
          if (cnt_q <= 8'h01) begin
            flash_ce_n <= 1'b0;
            flash_we_n <= rd_q;
            flash_oe_n <= !rd_q;
            cnt_q      <= rd_q ? RPULSE_CYC : WPULSE_CYC;
            ph_q       <= PH_PULSE;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        PH_PULSE: begin
          if (cnt_q <= 8'h01) begin
            rdata      <= flash_dq_i;
            flash_ce_n <= 1'b1;
            flash_we_n <= 1'b1;
            flash_oe_n <= 1'b1;
            cnt_q      <= HOLD_CYC;
            ph_q       <= PH_HOLD;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        PH_HOLD: begin
          // data held past the strobes' rise
          if (cnt_q <= 8'h01) begin
            flash_dq_oe <= 1'b0;
            done        <= 1'b1;
            ph_q        <= PH_IDLE;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        default: ph_q <= PH_IDLE;
      endcase
    end
  end

endmodule

// [flash_host.sv]
`timescale 1ns/100ps
// Summary of operation
// - all command cycles are writes except array read and identification reads
// - plain array read needs no unlock or command cycles
// - host writes reset after identification mode or a timeout failure in DQ7 or toggle polling; pin mode never detects a timeout
// - identification reads carry bank address; device id read over three cycles
// - bypass program only after bypass entry; bypass reset leaves it
// - program poll: bit 7 inverted until done; read at program address
// - erase poll: bit 7 reads 0, then 1; read inside selected sector
// - after polling completes, take valid data from the following read
// - re-read polling bit after seeing timeout bit high
module flash_host
  import flash_host_pkg::*;
#(
  parameter int AW = 22,
  parameter int DW = 16
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          sys_rst,
  // apb slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  // flash pins
  output logic [AW-1:0]      flash_addr,
  output logic [DW-1:0]      flash_dq_o,
  output logic               flash_dq_oe,
  input  wire logic [DW-1:0] flash_dq_i,
  output logic               flash_ce_n,
  output logic               flash_we_n,
  output logic               flash_oe_n,
  input  wire logic          ready_busy_n
);

  typedef enum logic [3:0] {S_IDLE, S_ISSUE, S_WAIT, S_POLL, S_POLL_W, S_RBW,
                            S_FIN, S_FIN_W, S_RST, S_RST_W} state_e;

  state_e          state_q;
  logic [3:0]      cmd_q;
  logic [1:0]      mode_q;
  logic [AW-1:0]   addr_q;
  logic [DW-1:0]   wdata_q;
  logic [DW-1:0]   rdata_q [3];
  logic [2:0]      idx_q;
  logic [1:0]      rd_cnt_q;
  logic [7:0]      wait_q;
  logic            done_q, fail_q, refused_q, bypass_q, susp_q;
  logic            recheck_q, tog_first_q, tog_prev_q;
  logic            wr_en, start_ok, start_req, refuse;
  logic [1:0]      k_kind;
  logic [AW-1:0]   k_addr;
  logic [DW-1:0]   k_data;
  logic            cyc_start, cyc_read, cyc_done;
  logic [AW-1:0]   cyc_addr;
  logic [DW-1:0]   cyc_wdata, cyc_rdata;
  logic            poll_ok;

  function automatic logic [AW-1:0] bank(input logic [AW-1:0] a, input logic [10:0] o);
    return {a[AW-1:11], o};
  endfunction

  // command step table, word mode
  always_comb begin
    k_kind = K_END;
    k_addr = '0;
    k_data = '0;
    case (cmd_q)
      CMD_READ: if (idx_q == 3'd0) begin
        k_kind = K_RD;
        k_addr = addr_q;
      end
      CMD_RESET: if (idx_q == 3'd0) begin
        k_kind = K_WR;
        k_data = 16'h00f0;
      end
      CMD_BYP_PROG: case (idx_q)
        3'd0: begin k_kind = K_WR; k_data = 16'h00a0; end
        3'd1: begin k_kind = K_WR; k_addr = addr_q; k_data = wdata_q; end
        3'd2: k_kind = K_POLL;
        default: k_kind = K_END;
      endcase
      CMD_BYP_RESET: case (idx_q)
        3'd0: begin k_kind = K_WR; k_addr = bank(addr_q, 11'h000); k_data = 16'h0090; end
        3'd1: begin k_kind = K_WR; k_data = 16'h0000; end
        default: k_kind = K_END;
      endcase
      CMD_SUSPEND: if (idx_q == 3'd0) begin
        k_kind = K_WR;
        k_addr = bank(addr_q, 11'h000);
        k_data = 16'h00b0;
      end
      CMD_RESUME: if (idx_q == 3'd0) begin
        k_kind = K_WR;
        k_addr = bank(addr_q, 11'h000);
        k_data = 16'h0030;
      end
      default: begin
        // unlocked sequences; unlock cycles leave upper address and data byte zero
        if (idx_q == 3'd0 || idx_q == 3'd3) begin
          k_kind = K_WR; k_addr = {{(AW-11){1'b0}}, U_555}; k_data = 16'h00aa;
        end else if (idx_q == 3'd1 || idx_q == 3'd4) begin
          k_kind = K_WR; k_addr = {{(AW-11){1'b0}}, U_2AA}; k_data = 16'h0055;
        end
        case ({cmd_q, idx_q})
          {CMD_PROG, 3'd2}:       begin k_kind = K_WR; k_data = 16'h00a0;
                                        k_addr = {{(AW-11){1'b0}}, U_555}; end
          {CMD_PROG, 3'd3}:       begin k_kind = K_WR; k_addr = addr_q; k_data = wdata_q; end
          {CMD_PROG, 3'd4}:       k_kind = K_POLL;
          {CMD_BYP_ENTER, 3'd2}:  begin k_kind = K_WR; k_data = 16'h0020;
                                        k_addr = {{(AW-11){1'b0}}, U_555}; end
          {CMD_CHIP_ERASE, 3'd2},
          {CMD_SECT_ERASE, 3'd2}: begin k_kind = K_WR; k_data = 16'h0080;
                                        k_addr = {{(AW-11){1'b0}}, U_555}; end
          {CMD_CHIP_ERASE, 3'd5}: begin k_kind = K_WR; k_data = 16'h0010;
                                        k_addr = {{(AW-11){1'b0}}, U_555}; end
          {CMD_SECT_ERASE, 3'd5}: begin k_kind = K_WR; k_addr = addr_q; k_data = 16'h0030; end
          {CMD_CHIP_ERASE, 3'd6},
          {CMD_SECT_ERASE, 3'd6}: k_kind = K_POLL;
          {CMD_AUTOSEL, 3'd2},
          {CMD_QUERY, 3'd2}:      begin k_kind = K_WR; k_addr = bank(addr_q, U_555);
                                        k_data = 16'h0090; end
          {CMD_AUTOSEL, 3'd3}:    begin k_kind = K_RD; k_addr = bank(addr_q, ID_1); end
          {CMD_AUTOSEL, 3'd4}:    begin k_kind = K_RD; k_addr = bank(addr_q, ID_2); end
          {CMD_AUTOSEL, 3'd5}:    begin k_kind = K_RD; k_addr = bank(addr_q, ID_3); end
          {CMD_QUERY, 3'd3}:      begin k_kind = K_RD; k_addr = addr_q; end
          {CMD_AUTOSEL, 3'd6},
          {CMD_QUERY, 3'd4}:      begin k_kind = K_WR; k_addr = '0; k_data = 16'h00f0; end
          default: if (idx_q > 3'd1 && !((cmd_q == CMD_CHIP_ERASE || cmd_q == CMD_SECT_ERASE)
                                         && idx_q < 3'd5)) k_kind = K_END;
        endcase
      end
    endcase
  end

  // bus cycle request
  always_comb begin
    cyc_start = 1'b0;
    cyc_read  = 1'b1;
    cyc_addr  = addr_q;
    cyc_wdata = '0;
    case (state_q)
      S_ISSUE: begin
        cyc_start = (k_kind == K_WR) || (k_kind == K_RD);
        cyc_read  = (k_kind == K_RD);
        cyc_addr  = k_addr;
        cyc_wdata = k_data;
      end
      S_POLL, S_FIN: cyc_start = 1'b1;
      S_RST: begin
        cyc_start = 1'b1;
        cyc_read  = 1'b0;
        cyc_addr  = '0;
        cyc_wdata = 16'h00f0;
      end
      default: cyc_start = 1'b0;
    endcase
  end

  flash_cycle #(.AW(AW), .DW(DW)) u_flash_cycle (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .start       (cyc_start),
    .is_read     (cyc_read),
    .addr        (cyc_addr),
    .wdata       (cyc_wdata),
    .done        (cyc_done),
    .rdata       (cyc_rdata),
    .flash_addr  (flash_addr),
    .flash_dq_o  (flash_dq_o),
    .flash_dq_oe (flash_dq_oe),
    .flash_dq_i  (flash_dq_i),
    .flash_ce_n  (flash_ce_n),
    .flash_we_n  (flash_we_n),
    .flash_oe_n  (flash_oe_n)
  );

  // apb access
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign refuse = (pwdata[3:0] == CMD_BYP_PROG && !bypass_q)
               || (pwdata[3:0] == CMD_RESUME && !susp_q) || (pwdata[3:0] > CMD_QUERY);
  assign start_req = wr_en && paddr == OFS_CTRL && state_q == S_IDLE;
  assign start_ok = start_req && !refuse;

  always_comb begin
    prdata  = 32'h0000_0000;
    pslverr = 1'b0;
    case (paddr)
      OFS_CTRL:   prdata = {26'h0, mode_q, cmd_q};
      OFS_ADDR:   prdata = 32'(addr_q);
      OFS_WDATA:  prdata = 32'(wdata_q);
      OFS_STATUS: prdata = {25'h0, susp_q, refused_q, ready_busy_n, bypass_q, fail_q, done_q,
                            state_q != S_IDLE};
      OFS_RDATA0: prdata = 32'(rdata_q[0]);
      OFS_RDATA1: prdata = 32'(rdata_q[1]);
      OFS_RDATA2: prdata = 32'(rdata_q[2]);
      default:    pslverr = psel && penable;
    endcase
  end

  // software registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_q     <= CTRL_RST[3:0];
      mode_q    <= CTRL_RST[5:4];
      addr_q    <= '0;
      wdata_q   <= '0;
      refused_q <= 1'b0;
    end else begin
      if (start_req) begin
        refused_q <= refuse;
      end
      if (start_ok) begin
        cmd_q  <= pwdata[CTRL_CMD_LSB +: 4];
        mode_q <= pwdata[CTRL_MODE_LSB +: 2];
      end
      if (wr_en && paddr == OFS_ADDR && state_q == S_IDLE) begin
        addr_q <= pwdata[AW-1:0];
      end
      if (wr_en && paddr == OFS_WDATA && state_q == S_IDLE) begin
        wdata_q <= pwdata[DW-1:0];
      end
    end
  end

  // completion check of one poll read
  always_comb begin
    if (mode_q == MODE_TOGGLE) begin
      poll_ok = !tog_first_q && (cyc_rdata[6] == tog_prev_q);
    end else if (cmd_q == CMD_PROG || cmd_q == CMD_BYP_PROG) begin
      poll_ok = cyc_rdata[7] == wdata_q[7];
    end else begin
      poll_ok = cyc_rdata[7];
    end
  end

  // sequencer
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q     <= S_IDLE;
      idx_q       <= 3'd0;
      rd_cnt_q    <= 2'd0;
      wait_q      <= 8'h00;
      done_q      <= 1'b0;
      fail_q      <= 1'b0;
      recheck_q   <= 1'b0;
      tog_first_q <= 1'b1;
      tog_prev_q  <= 1'b0;
    end else begin
      case (state_q)
        S_IDLE: if (start_ok) begin
          state_q     <= S_ISSUE;
          idx_q       <= 3'd0;
          rd_cnt_q    <= 2'd0;
          done_q      <= 1'b0;
          fail_q      <= 1'b0;
          recheck_q   <= 1'b0;
          tog_first_q <= 1'b1;
        end
        S_ISSUE: begin
          if (k_kind == K_END) begin
            state_q <= S_IDLE;
            done_q  <= 1'b1;
          end else if (k_kind == K_POLL) begin
            wait_q  <= BUSY_CYC;
            state_q <= (mode_q == MODE_PIN) ? S_RBW : S_POLL;
          end else begin
            state_q <= S_WAIT;
          end
        end
        S_WAIT: if (cyc_done) begin
          if (k_kind == K_RD) begin
            rd_cnt_q <= rd_cnt_q + 2'd1;
          end
          idx_q   <= idx_q + 3'd1;
          state_q <= S_ISSUE;
        end
        S_POLL: state_q <= S_POLL_W;
        S_POLL_W: if (cyc_done) begin
          tog_prev_q <= cyc_rdata[6];
          if (poll_ok) begin
            state_q <= S_FIN;
          end else if (mode_q == MODE_TOGGLE && tog_first_q) begin
            tog_first_q <= 1'b0;
            state_q     <= S_POLL;
          end else if (cyc_rdata[5]) begin
            recheck_q   <= 1'b1;
            tog_first_q <= 1'b1;
            state_q     <= recheck_q ? S_RST : S_POLL;
          end else begin
            tog_first_q <= 1'b1;
            state_q     <= S_POLL;
          end
        end
        S_RBW: begin
          if (wait_q != 8'h00) begin
            wait_q <= wait_q - 8'h01;
          end else if (ready_busy_n) begin
            state_q <= S_FIN;
          end
        end
        S_FIN: state_q <= S_FIN_W;
        S_FIN_W: if (cyc_done) begin
          state_q <= S_IDLE;
          done_q  <= 1'b1;
        end
        S_RST: state_q <= S_RST_W;
        S_RST_W: if (cyc_done) begin
          state_q <= S_IDLE;
          fail_q  <= 1'b1;
          done_q  <= 1'b1;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // read capture
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= '{default: '0};
    end else if (cyc_done && state_q == S_WAIT && k_kind == K_RD) begin
      rdata_q[rd_cnt_q] <= cyc_rdata;
    end else if (cyc_done && state_q == S_FIN_W) begin
      rdata_q[0] <= cyc_rdata;
    end
  end

  // mode flags
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bypass_q <= 1'b0;
      susp_q   <= 1'b0;
    end else if (state_q == S_ISSUE && k_kind == K_END) begin
      if (cmd_q == CMD_BYP_ENTER) bypass_q <= 1'b1;
      if (cmd_q == CMD_BYP_RESET) bypass_q <= 1'b0;
      if (cmd_q == CMD_SUSPEND) susp_q <= 1'b1;
      if (cmd_q == CMD_RESUME) susp_q <= 1'b0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_read_cmd;
    start_ok && pwdata[3:0] == CMD_READ;
  endsequence
  sequence s_first_read;
    cyc_start && cyc_read && cyc_addr == addr_q;
  endsequence

  property p_read_direct;
    s_read_cmd |=> s_first_read;
  endproperty
  a_read_direct: assert property (p_read_direct) else $error("read issued command cycles");

  property p_write_strobe_only;
    (state_q == S_ISSUE && cyc_start && !cyc_read) |-> k_kind == K_WR;
  endproperty
  a_write_strobe_only: assert property (p_write_strobe_only) else $error("bad cycle kind");

  property p_bypass_gate;
    (start_ok && pwdata[3:0] == CMD_BYP_PROG) |-> bypass_q;
  endproperty
  a_bypass_gate: assert property (p_bypass_gate) else $error("bypass program outside bypass");

  property p_fail_reset;
    $rose(fail_q) |-> $past(state_q) == S_RST_W && flash_dq_o == 16'h00f0;
  endproperty
  a_fail_reset: assert property (p_fail_reset) else $error("failure without reset write");

  property p_id_bank;
    (state_q == S_ISSUE && cmd_q == CMD_AUTOSEL && k_kind == K_RD)
      |-> cyc_addr[AW-1:11] == addr_q[AW-1:11];
  endproperty
  a_id_bank: assert property (p_id_bank) else $error("id read without bank address");

  property p_poll_addr;
    (state_q == S_POLL) |-> cyc_start && cyc_read && cyc_addr == addr_q ##1 state_q == S_POLL_W;
  endproperty
  a_poll_addr: assert property (p_poll_addr) else $error("poll read at wrong address");

  property p_final_read;
    (state_q == S_POLL_W && cyc_done && poll_ok) |=> state_q == S_FIN ##1 state_q == S_FIN_W;
  endproperty
  a_final_read: assert property (p_final_read) else $error("no data read after poll");

  property p_recheck;
    (state_q == S_POLL_W && cyc_done && !poll_ok && cyc_rdata[5] && !recheck_q
      && !(mode_q == MODE_TOGGLE && tog_first_q)) |=> state_q == S_POLL && recheck_q;
  endproperty
  a_recheck: assert property (p_recheck) else $error("timeout bit not rechecked");

  property p_erase_expect;
    (state_q == S_POLL_W && mode_q == MODE_DQ7 && cmd_q == CMD_SECT_ERASE)
      |-> poll_ok == cyc_rdata[7];
  endproperty
  a_erase_expect: assert property (p_erase_expect) else $error("erase poll sense wrong");

endmodule

// [flash_model.sv]
`timescale 1ns/100ps
module flash_model #(
  parameter logic [7:0] ID_KEY = 8'h5a  // arbitrary id pattern
) (
  // pins
  input  wire logic [21:0] flash_addr,
  input  wire logic [15:0] flash_dq_o,
  input  wire logic        flash_ce_n,
  input  wire logic        flash_we_n,
  input  wire logic        flash_oe_n,
  output logic      [15:0] flash_dq_i,
  output logic             ready_busy_n,
  // fault knob
  input  wire logic        fail_en
);
  logic [15:0] mem [256];
  logic [21:0] a;
  logic [15:0] v;
  logic [15:0] lastv = '0;
  logic [7:0]  h1 = '0;
  logic [7:0]  h2 = '0;
  logic        busy = 0, prg = 0, tog = 0, ids = 0, nxt = 0, byp = 0;
  wire         ws = flash_ce_n | flash_we_n;
  wire         rs = flash_ce_n | flash_oe_n;
  wire  [7:0]  d = flash_dq_o[7:0];
  initial foreach (mem[i]) mem[i] = '1;
  always @(negedge ws) a = flash_addr;
  always @(posedge ws) begin
    if (nxt) begin
      mem[a[7:0]] = flash_dq_o;
      prg = 1;
      busy = 1;
      nxt = 0;
    end else if (d == 8'hf0) begin
      busy = 0;
      ids = 0;
    end else if (byp) begin
      nxt = d == 8'ha0;
      if (h2 == 8'h90 && d == 8'h00) byp = 0;
    end else if (h1 == 8'haa && h2 == 8'h55) begin
      nxt = d == 8'ha0;
      if (d == 8'h20) byp = 1;
      if (d == 8'h90) ids = 1;
      if (d == 8'h30 || d == 8'h10) begin
        prg = 0;
        busy = 1;
      end
    end
    h1 = h2;
    h2 = d;
  end
  always @(posedge busy) begin
    #800;
    if (!fail_en && busy) begin
      if (!prg) foreach (mem[i]) mem[i] = '1;
      busy = 0;
    end
  end
  always @(posedge rs) if (busy) tog = ~tog;
  always @* begin
    if (busy) v = {8'h0, prg ? ~mem[flash_addr[7:0]][7] : 1'b0, tog, fail_en, 5'h0};
    else if (ids) v = flash_addr[7:0] == 8'h02 ? 16'h0 :
      flash_addr[7:0] == 8'h03 ? 16'h80 : {8'h0, {4'h0, flash_addr[3:0]} ^ ID_KEY};
    else v = mem[flash_addr[7:0]];
    if (!rs) lastv = v;
  end
  assign flash_dq_i = rs ? ~lastv : v;
  assign ready_busy_n = ~busy;
endmodule

// [flash_host_test.sv]
`timescale 1ns/100ps
module flash_host_test;
  import flash_host_pkg::*;
  localparam logic [7:0] K = 8'h5a;
  logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, fail_en = 0, err;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0, prdata, rv;
  logic pready, pslverr, flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n, ready_busy_n;
  logic [21:0] flash_addr;
  logic [15:0] flash_dq_o, flash_dq_i;
  int fails = 0, n_checks = 0;
  always #4 clk = ~clk;
  flash_host u_flash_host (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .flash_addr, .flash_dq_o, .flash_dq_oe, .flash_dq_i,
    .flash_ce_n, .flash_we_n, .flash_oe_n, .ready_busy_n);
  flash_model #(.ID_KEY(K)) u_flash_model (.flash_addr, .flash_dq_o, .flash_ce_n,
    .flash_we_n, .flash_oe_n, .flash_dq_i, .ready_busy_n, .fail_en);
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) penable <= 1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rv = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    if (n >= 20) begin
      fails++;
      final_report();
    end
    @(posedge clk);
  endtask
  task automatic run(input logic [3:0] c, input logic [1:0] m, input logic [21:0] ad,
                     input logic [15:0] d);
    int n;
    n = 0;
    apb(1, OFS_ADDR, 32'(ad));
    apb(1, OFS_WDATA, 32'(d));
    apb(1, OFS_CTRL, {26'h0, m, c});
    do begin
      apb(0, OFS_STATUS, 0);
      n++;
    end while (rv[ST_DONE] !== 1'b1 && n < 500);
    if (n >= 500) begin
      fails++;
      final_report();
    end
  endtask
  task automatic t_prog();
    run(CMD_PROG, MODE_DQ7, 22'h12, 16'h1234);
    chk(rv[2:0], 3'b010);
    apb(0, OFS_RDATA0, 0);
    chk(rv[15:0], 16'h1234);
    run(CMD_PROG, MODE_PIN, 22'h13, 16'h00ab);
    apb(0, OFS_RDATA0, 0);
    chk(rv[15:0], 16'h00ab);
    run(CMD_SECT_ERASE, MODE_TOGGLE, 22'h12, 0);
    run(CMD_READ, MODE_DQ7, 22'h13, 0);
    apb(0, OFS_RDATA0, 0);
    chk(rv[15:0], 16'hffff);
    $display("program and erase done");
  endtask
  task automatic t_id();
    logic [3:0] o[3] = '{4'h1, 4'he, 4'hf};
    run(CMD_AUTOSEL, MODE_DQ7, 0, 0);
    foreach (o[i]) begin
      apb(0, OFS_RDATA0 + 8'(4 * i), 0);
      chk(rv[7:0], {4'h0, o[i]} ^ K);
    end
    for (int q = 2; q < 4; q++) begin
      run(CMD_QUERY, MODE_DQ7, 22'(q), 0);
      apb(0, OFS_RDATA0, 0);
      chk(rv[7:0], q == 3 ? 8'h80 : 8'h00);
    end
    $display("identification done");
  endtask
  task automatic t_modes();
    run(CMD_BYP_ENTER, MODE_DQ7, 0, 0);
    chk({31'h0, rv[ST_BYPASS]}, 1);
    run(CMD_BYP_PROG, MODE_DQ7, 22'h30, 16'h0080);
    apb(0, OFS_RDATA0, 0);
    chk(rv[15:0], 16'h0080);
    run(CMD_BYP_RESET, MODE_DQ7, 0, 0);
    chk({31'h0, rv[ST_BYPASS]}, 0);
    run(CMD_SECT_ERASE, MODE_DQ7, 22'h30, 0);
    apb(0, OFS_RDATA0, 0);
    chk(rv[15:0], 16'hffff);
    run(CMD_PROG, MODE_TOGGLE, 22'h31, 16'h0001);
    run(CMD_CHIP_ERASE, MODE_PIN, 0, 0);
    run(CMD_READ, MODE_DQ7, 22'h31, 0);
    apb(0, OFS_RDATA0, 0);
    chk(rv[15:0], 16'hffff);
    run(CMD_SUSPEND, MODE_DQ7, 0, 0);
    chk({31'h0, rv[ST_SUSP]}, 1);
    run(CMD_RESUME, MODE_DQ7, 0, 0);
    chk(rv[6:5], 2'b00);
    $display("modes done");
  endtask
  task automatic t_fail();
    fail_en <= 1;
    run(CMD_PROG, MODE_DQ7, 22'h20, 16'h0055);
    chk(rv[2:0], 3'b110);
    chk({31'h0, ready_busy_n}, 1);
    fail_en <= 0;
    apb(1, OFS_CTRL, {28'h0, CMD_RESUME});
    apb(0, OFS_STATUS, 0);
    chk({31'h0, rv[ST_REFUSED]}, 1);
    apb(1, OFS_CTRL, {28'h0, CMD_BYP_PROG});
    apb(0, OFS_STATUS, 0);
    chk({31'h0, rv[ST_REFUSED]}, 1);
    apb(0, 8'h40, 0);
    chk({31'h0, err}, 1);
    $display("faults done");
  endtask
  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 0;
    @(posedge clk);
    apb(0, OFS_STATUS, 0);
    chk(rv, 32'h10);
    t_prog();
    t_id();
    t_modes();
    t_fail();
    final_report();
  end
endmodule
